//--- rtl/hcg_clock_params.svh
/*
 * constants of the host clock generator: register offsets, field
 * positions, reset values and bus answers.
 * assumes inclusion by bare name into each design file that needs them.
 */
`ifndef HCG_CLOCK_PARAMS_SVH
`define HCG_CLOCK_PARAMS_SVH

// register byte offsets on the register bus
`define HCG_OFF_RCW 8'h00
`define HCG_OFF_OUTPUT_CLOCK_CONTROL_REG 8'h04
`define HCG_OFF_SYSTEM_CLOCK_CONTROL_REG 8'h08
`define HCG_OFF_LOCAL_BUS_CLOCK_CONTROL 8'h0C
`define HCG_OFF_STAT 8'h10

// reset configuration word low field positions
`define HCG_RCW_LOCAL_BUS_CLOCK_MODE 0
`define HCG_RCW_MEMORY_CLOCK_MODE 1
`define HCG_RCW_SYSTEM_PLL_MULTIPLIER_LO 4
`define HCG_RCW_SYSTEM_PLL_MULTIPLIER_HI 7
`define HCG_RCW_CORE_LO 8
`define HCG_RCW_CORE_HI 14
// word used when the hard-coded reset option is selected
`define HCG_RCW_HARD 32'h0000_0040

// unit clock-ratio fields, two bits each: eth1, eth2/i2c1, sec, usb dr, usb mph
`define HCG_SYSTEM_CLOCK_CONTROL_REG_TOP 31
`define HCG_SYSTEM_CLOCK_CONTROL_REG_PCI 0
`define HCG_SYSTEM_CLOCK_CONTROL_REG_RST 32'hFFC0_0001
`define HCG_OUTPUT_CLOCK_CONTROL_REG_RST 32'h0000_0000
`define HCG_LOCAL_BUS_CLOCK_CONTROL_RST 32'h0000_0000

// ratio encodings
`define HCG_MODE_OFF 2'h0
`define HCG_MODE_FULL 2'h1
`define HCG_MODE_HALF 2'h2
`define HCG_MODE_THIRD 2'h3

// system pll multiplier codes
`define HCG_SYSTEM_PLL_MULTIPLIER_X16 4'h0
`define HCG_SYSTEM_PLL_MULTIPLIER_RSVD 4'h1
`define HCG_MULT_X16 6'h10

// local bus divider codes and half-period counts
`define HCG_LDIV_2 2'h0
`define HCG_LDIV_4 2'h1
`define HCG_HALF_2 3'h1
`define HCG_HALF_4 3'h2
`define HCG_HALF_8 3'h4

// status field positions
`define HCG_ST_DDR 8
`define HCG_ST_LBIU 9
`define HCG_ST_HOST 10
`define HCG_ST_RSVD 11

// bus answers
`define HCG_RESP_OKAY 2'h0
`define HCG_RESP_SLVERR 2'h2

`endif

//--- rtl/hcg_pkg.sv
/*
 * types shared by the clock generator modules.
 * assumes the constants header supplies all numeric values.
 */
package hcg_pkg;
   typedef logic [1:0] hcg_mode_t;       // unit clock ratio code
   typedef enum logic [0:0] {HCG_W_IDLE, HCG_W_RESP} hcg_wstate_t; // write channel
   typedef enum logic [0:0] {HCG_R_IDLE, HCG_R_DATA} hcg_rstate_t; // read channel
endpackage : hcg_pkg

//--- rtl/hcg_gate_if.sv
/*
 * carrier between the top and one ratio gate.
 * assumes the top drives the requested ratio and reads the gate back.
 */
`timescale 1ns/100ps
interface hcg_gate_if;
   hcg_pkg::hcg_mode_t req_mode; // ratio asked for by software
   hcg_pkg::hcg_mode_t cur_mode; // ratio in force
   logic tick;                   // unit clock edge strobe
   modport ctl (output req_mode, input cur_mode, input tick);
   modport gate (input req_mode, output cur_mode, output tick);
endinterface : hcg_gate_if

//--- rtl/hcg_ratio_gate.sv
/*
 * one unit clock gate: full, half, third rate or off, as strobes on aclk.
 * assumes aclk stands for the system bus clock and reset is synchronous.
 */
`timescale 1ns/100ps
`include "hcg_clock_params.svh"
module hcg_ratio_gate #(
   parameter hcg_pkg::hcg_mode_t RST_MODE = `HCG_MODE_THIRD // ratio out of reset
) (
   input wire logic aclk,     // system bus clock
   input wire logic aresetn,  // sync reset, low active
   hcg_gate_if.gate gif       // request in, strobe out
);
   hcg_pkg::hcg_mode_t mode_r, mode_nxt; // ratio in force
   logic [1:0] cnt_r, cnt_nxt;           // position in period
   logic tick_r, tick_nxt;               // strobe register
   logic [1:0] last;                     // final count of period

   // a new ratio is adopted only at a period boundary, so no runt edge
   always_comb begin
      case (mode_r)
         `HCG_MODE_HALF: last = 2'h1;
         `HCG_MODE_THIRD: last = 2'h2;
         default: last = 2'h0;
      endcase
      if (cnt_r == last) begin
         cnt_nxt = 2'h0;
         mode_nxt = gif.req_mode;
      end else begin
         cnt_nxt = cnt_r + 2'h1;
         mode_nxt = mode_r;
      end
      tick_nxt = (cnt_nxt == 2'h0) && (mode_nxt != `HCG_MODE_OFF);
   end

   // registers only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_r <= RST_MODE;
         cnt_r <= 2'h0;
         tick_r <= 1'b0;
      end else begin
         mode_r <= mode_nxt;
         cnt_r <= cnt_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign gif.cur_mode = mode_r;
   assign gif.tick = tick_r;

   sequence s_third_gap;
      !tick_r ##1 !tick_r ##1 (tick_r || mode_r == `HCG_MODE_OFF);
   endsequence

   AST_MODE_AT_BOUNDARY: assert property (@(posedge aclk) disable iff (!aresetn)
      $changed(mode_r) |-> $past(cnt_r) == $past(last))
      else $error("ratio changed inside a period");
   AST_OFF_SILENT: assert property (@(posedge aclk) disable iff (!aresetn)
      mode_r == `HCG_MODE_OFF |-> !tick_r)
      else $error("strobe while unit is off");
   AST_THIRD_RATE: assert property (@(posedge aclk) disable iff (!aresetn)
      (tick_r && mode_r == `HCG_MODE_THIRD && gif.req_mode == `HCG_MODE_THIRD) |=> s_third_gap)
      else $error("third rate strobe spacing wrong");
endmodule : hcg_ratio_gate

//--- rtl/hcg_clock_unit.sv
/*
 * host processor clock generator: reference select, sync and bus clock
 * outputs, ratio decode, memory and local bus clocks, unit ratio gates,
 * register file on an axi4-lite slave.
 * assumes every pin input is synchronous to aclk, aclk stands for the
 * system bus clock, and the board loops sync out back to sync in.
 */
// Behaviour
// - host role uses dedicated primary input
// - agent role uses incoming bus clock
// - host halves input; strap picks sync output
// - per-output select bit picks full or half
// - tree follows sync input; board loops it
// - system ratio is (1+halve) times multiplier
// - core multiplier from config word at reset
// - memory clock ratio; pair runs at half
// - local unit ratio; divider makes bus clock
// - units reset to default ratio, software changes
// - five units default third; bus complex full/off
// - multiplier code 0 is sixteen, 1 reserved
// - local divider gives half, quarter or eighth
`timescale 1ns/100ps
`include "hcg_clock_params.svh"
module hcg_clock_unit (
   input wire logic aclk,                 // system bus clock, 250 MHz
   input wire logic aresetn,              // sync reset, low active
   input wire logic [7:0] awaddr,         // write address
   input wire logic awvalid,              // write address valid
   output logic awready,                  // write address ready
   input wire logic [31:0] wdata,         // write data
   input wire logic [3:0] wstrb,          // write byte lanes
   input wire logic wvalid,               // write data valid
   output logic wready,                   // write data ready
   output logic [1:0] bresp,              // write answer
   output logic bvalid,                   // write answer valid
   input wire logic bready,               // write answer ready
   input wire logic [7:0] araddr,         // read address
   input wire logic arvalid,              // read address valid
   output logic arready,                  // read address ready
   output logic [31:0] rdata,             // read data
   output logic [1:0] rresp,              // read answer
   output logic rvalid,                   // read data valid
   input wire logic rready,               // read data ready
   input wire logic primary_input_clock,  // dedicated clock pin
   input wire logic pci_clock_in,         // incoming bus clock pin
   input wire logic bus_sync_in,          // looped back sync clock
   input wire logic host_role_strap,      // high: bus host role
   input wire logic input_halve_strap,    // high: sync out is halved, host role only
   input wire logic rcw_hard_sel,         // high: hard-coded config word
   input wire logic [31:0] rcw_in,        // config word from boot source
   output logic sync_clock_out,           // sync clock out
   output logic [2:0] bus_clock_output_n, // bus clock outputs
   output logic tree_phase,               // internal tree phase
   output logic memory_bus_clock_pair_p,  // memory clock, true
   output logic memory_bus_clock_pair_n,  // memory clock, complement
   output logic local_sync_clock_out,     // local bus sync clock
   output logic [2:0] local_bus_clock_out,// local bus clocks
   output logic [5:0] unit_clock_tick,    // unit clock strobes
   output logic [5:0] csb_ratio,          // system to sync ratio
   output logic [6:0] core_pll_setting    // core multiplier field
);
   // config and register group
   logic cfg_done_r, cfg_done_nxt;           // config captured
   logic host_r, host_nxt;                   // latched role
   logic halve_r, halve_nxt;                 // latched halve strap
   logic [31:0] rcw_r, rcw_nxt;              // reset config word low
   logic [31:0] output_clock_control_reg_r, output_clock_control_reg_nxt;            // output clock control
   logic [31:0] system_clock_control_reg_r, system_clock_control_reg_nxt;            // system clock control
   logic [31:0] local_bus_clock_control_r, local_bus_clock_control_nxt;            // local bus clock control
   logic [5:0] ratio_r, ratio_nxt;           // system ratio
   logic rsvd_r, rsvd_nxt;                   // reserved multiplier seen
   logic [5:0] system_pll_multiplier_mult;                    // decoded multiplier
   logic [3:0] system_pll_multiplier_code;                    // multiplier field
   // write channel
   hcg_pkg::hcg_wstate_t wst_r, wst_nxt;     // write state
   logic aw_have_r, aw_have_nxt;             // address held
   logic w_have_r, w_have_nxt;               // data held
   logic [7:0] aw_addr_r, aw_addr_nxt;       // held address
   logic [31:0] w_data_r, w_data_nxt;        // held data
   logic [3:0] w_strb_r, w_strb_nxt;         // held lanes
   logic [1:0] bresp_r, bresp_nxt;           // write answer
   // read channel
   hcg_pkg::hcg_rstate_t rst_r, rst_nxt;     // read state
   logic [31:0] rdata_r, rdata_nxt;          // read data
   logic [1:0] rresp_r, rresp_nxt;           // read answer
   logic [31:0] stat;                        // status word
   // clock path group
   logic ref_d_r, ref_d_nxt;                 // sampled reference
   logic half_r, half_nxt;                   // halved reference
   logic sync_r, sync_nxt;                   // sync out
   logic [2:0] bclk_r, bclk_nxt;             // bus clock outputs
   logic tree_r, tree_nxt;                   // tree phase
   logic mck_r, mck_nxt;                     // memory pair
   logic mck_n_r, mck_n_nxt; // memory pair complement, own flop so the pin is registered
   logic [2:0] lcnt_r, lcnt_nxt;             // local divider count
   logic local_bus_clock_out_r, local_bus_clock_out_nxt;                   // local bus clock
   logic [2:0] lhalf;                        // local half period
   logic ref_now;                            // selected reference
   logic [31:0] wmask;                       // lane mask

   hcg_gate_if gif [6] ();                   // unit gates

   // unit gates: five ratio units from the top of system_clock_control_reg, then the bus complex
   genvar gi;
   generate
      for (gi = 0; gi < 5; gi++) begin : g_unit
         assign gif[gi].req_mode = system_clock_control_reg_r[`HCG_SYSTEM_CLOCK_CONTROL_REG_TOP - 2*gi -: 2];
         hcg_ratio_gate #(.RST_MODE(`HCG_MODE_THIRD)) u_gate (
            .aclk(aclk),
            .aresetn(aresetn),
            .gif(gif[gi])
         );
         assign unit_clock_tick[gi] = gif[gi].tick;
      end
   endgenerate
   // bus complex: full or off only, so the low bit picks between them
   assign gif[5].req_mode = system_clock_control_reg_r[`HCG_SYSTEM_CLOCK_CONTROL_REG_PCI] ? `HCG_MODE_FULL : `HCG_MODE_OFF;
   hcg_ratio_gate #(.RST_MODE(`HCG_MODE_FULL)) u_gate_pci (
      .aclk(aclk),
      .aresetn(aresetn),
      .gif(gif[5])
   );
   assign unit_clock_tick[5] = gif[5].tick;

   // multiplier decode; reserved code falls back to the sixteen setting
   always_comb begin
      system_pll_multiplier_code = rcw_r[`HCG_RCW_SYSTEM_PLL_MULTIPLIER_HI:`HCG_RCW_SYSTEM_PLL_MULTIPLIER_LO];
      if (system_pll_multiplier_code == `HCG_SYSTEM_PLL_MULTIPLIER_X16 || system_pll_multiplier_code == `HCG_SYSTEM_PLL_MULTIPLIER_RSVD) begin
         system_pll_multiplier_mult = `HCG_MULT_X16;
      end else begin
         system_pll_multiplier_mult = {2'h0, system_pll_multiplier_code};
      end
   end

   // config capture, registers and write channel
   always_comb begin
      cfg_done_nxt = 1'b1;
      host_nxt = host_r;
      halve_nxt = halve_r;
      rcw_nxt = rcw_r;
      // straps and word caught once, the first cycle after reset release
      if (!cfg_done_r) begin
         host_nxt = host_role_strap;
         halve_nxt = input_halve_strap;
         rcw_nxt = rcw_hard_sel ? `HCG_RCW_HARD : rcw_in;
      end
      ratio_nxt = halve_r ? 6'(system_pll_multiplier_mult << 1) : system_pll_multiplier_mult;
      rsvd_nxt = (system_pll_multiplier_code == `HCG_SYSTEM_PLL_MULTIPLIER_RSVD);
      output_clock_control_reg_nxt = output_clock_control_reg_r;
      system_clock_control_reg_nxt = system_clock_control_reg_r;
      local_bus_clock_control_nxt = local_bus_clock_control_r;
      wst_nxt = wst_r;
      aw_have_nxt = aw_have_r;
      w_have_nxt = w_have_r;
      aw_addr_nxt = aw_addr_r;
      w_data_nxt = w_data_r;
      w_strb_nxt = w_strb_r;
      bresp_nxt = bresp_r;
      for (int b = 0; b < 4; b++) begin
         wmask[8*b +: 8] = {8{w_strb_r[b]}};
      end
      case (wst_r)
         hcg_pkg::HCG_W_IDLE: begin
            // address and data taken in either order
            if (awvalid && !aw_have_r) begin
               aw_have_nxt = 1'b1;
               aw_addr_nxt = awaddr;
            end
            if (wvalid && !w_have_r) begin
               w_have_nxt = 1'b1;
               w_data_nxt = wdata;
               w_strb_nxt = wstrb;
            end
            if (aw_have_r && w_have_r) begin
               aw_have_nxt = 1'b0;
               w_have_nxt = 1'b0;
               wst_nxt = hcg_pkg::HCG_W_RESP;
               bresp_nxt = `HCG_RESP_OKAY;
               case (aw_addr_r)
                  `HCG_OFF_OUTPUT_CLOCK_CONTROL_REG: output_clock_control_reg_nxt = (output_clock_control_reg_r & ~wmask) | (w_data_r & wmask);
                  `HCG_OFF_SYSTEM_CLOCK_CONTROL_REG: system_clock_control_reg_nxt = (system_clock_control_reg_r & ~wmask) | (w_data_r & wmask);
                  `HCG_OFF_LOCAL_BUS_CLOCK_CONTROL: local_bus_clock_control_nxt = (local_bus_clock_control_r & ~wmask) | (w_data_r & wmask);
                  `HCG_OFF_RCW, `HCG_OFF_STAT: bresp_nxt = `HCG_RESP_OKAY; // read only, ignored
                  default: bresp_nxt = `HCG_RESP_SLVERR;
               endcase
            end
         end
         hcg_pkg::HCG_W_RESP: begin
            if (bready) begin
               wst_nxt = hcg_pkg::HCG_W_IDLE;
            end
         end
         default: wst_nxt = hcg_pkg::HCG_W_IDLE;
      endcase
   end

   // registers of the config and write group
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_done_r <= 1'b0;
         host_r <= 1'b0;
         halve_r <= 1'b0;
         rcw_r <= 32'h0000_0000;
         ratio_r <= 6'h00;
         rsvd_r <= 1'b0;
         output_clock_control_reg_r <= `HCG_OUTPUT_CLOCK_CONTROL_REG_RST;
         system_clock_control_reg_r <= `HCG_SYSTEM_CLOCK_CONTROL_REG_RST;
         local_bus_clock_control_r <= `HCG_LOCAL_BUS_CLOCK_CONTROL_RST;
         wst_r <= hcg_pkg::HCG_W_IDLE;
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
         bresp_r <= `HCG_RESP_OKAY;
      end else begin
         cfg_done_r <= cfg_done_nxt;
         host_r <= host_nxt;
         halve_r <= halve_nxt;
         rcw_r <= rcw_nxt;
         ratio_r <= ratio_nxt;
         rsvd_r <= rsvd_nxt;
         output_clock_control_reg_r <= output_clock_control_reg_nxt;
         system_clock_control_reg_r <= system_clock_control_reg_nxt;
         local_bus_clock_control_r <= local_bus_clock_control_nxt;
         wst_r <= wst_nxt;
         aw_have_r <= aw_have_nxt;
         w_have_r <= w_have_nxt;
         aw_addr_r <= aw_addr_nxt;
         w_data_r <= w_data_nxt;
         w_strb_r <= w_strb_nxt;
         bresp_r <= bresp_nxt;
      end
   end

   // read channel; status shows derived ratios and latched role
   always_comb begin
      stat = {20'h0_0000, rsvd_r, host_r, rcw_r[`HCG_RCW_LOCAL_BUS_CLOCK_MODE], rcw_r[`HCG_RCW_MEMORY_CLOCK_MODE], 2'h0, ratio_r};
      rst_nxt = rst_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      case (rst_r)
         hcg_pkg::HCG_R_IDLE: begin
            if (arvalid) begin
               rst_nxt = hcg_pkg::HCG_R_DATA;
               rresp_nxt = `HCG_RESP_OKAY;
               case (araddr)
                  `HCG_OFF_RCW: rdata_nxt = rcw_r;
                  `HCG_OFF_OUTPUT_CLOCK_CONTROL_REG: rdata_nxt = output_clock_control_reg_r;
                  `HCG_OFF_SYSTEM_CLOCK_CONTROL_REG: rdata_nxt = system_clock_control_reg_r;
                  `HCG_OFF_LOCAL_BUS_CLOCK_CONTROL: rdata_nxt = local_bus_clock_control_r;
                  `HCG_OFF_STAT: rdata_nxt = stat;
                  default: begin
                     rdata_nxt = 32'h0000_0000;
                     rresp_nxt = `HCG_RESP_SLVERR;
                  end
               endcase
            end
         end
         hcg_pkg::HCG_R_DATA: begin
            if (rready) begin
               rst_nxt = hcg_pkg::HCG_R_IDLE;
            end
         end
         default: rst_nxt = hcg_pkg::HCG_R_IDLE;
      endcase
   end

   // registers of the read group
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rst_r <= hcg_pkg::HCG_R_IDLE;
         rdata_r <= 32'h0000_0000;
         rresp_r <= `HCG_RESP_OKAY;
      end else begin
         rst_r <= rst_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
      end
   end

   // clock paths; pins are sampled, so sync and bus clock outputs trail the pins by two cycles, tree phase by one
   always_comb begin
      ref_now = host_r ? primary_input_clock : pci_clock_in;
      ref_d_nxt = ref_now;
      // halver only advances on a rising reference edge
      half_nxt = (host_r && ref_now && !ref_d_r) ? !half_r : half_r;
      sync_nxt = halve_r ? half_r : ref_d_r;
      for (int k = 0; k < 3; k++) begin
         bclk_nxt[k] = output_clock_control_reg_r[k] ? half_r : ref_d_r;
      end
      tree_nxt = bus_sync_in;
      mck_nxt = !mck_r;
      mck_n_nxt = !mck_n_r;
      case (local_bus_clock_control_r[1:0])
         `HCG_LDIV_2: lhalf = `HCG_HALF_2;
         `HCG_LDIV_4: lhalf = `HCG_HALF_4;
         default: lhalf = `HCG_HALF_8;
      endcase
      // divider turns only at a half-period end, so no runt local clock
      if (lcnt_r >= lhalf - 3'h1) begin
         lcnt_nxt = 3'h0;
         local_bus_clock_out_nxt = !local_bus_clock_out_r;
      end else begin
         lcnt_nxt = lcnt_r + 3'h1;
         local_bus_clock_out_nxt = local_bus_clock_out_r;
      end
   end

   // registers of the clock path group
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ref_d_r <= 1'b0;
         half_r <= 1'b0;
         sync_r <= 1'b0;
         bclk_r <= 3'h0;
         tree_r <= 1'b0;
         mck_r <= 1'b0;
         mck_n_r <= 1'b1;
         lcnt_r <= 3'h0;
         local_bus_clock_out_r <= 1'b0;
      end else begin
         ref_d_r <= ref_d_nxt;
         half_r <= half_nxt;
         sync_r <= sync_nxt;
         bclk_r <= bclk_nxt;
         tree_r <= tree_nxt;
         mck_r <= mck_nxt;
         mck_n_r <= mck_n_nxt;
         lcnt_r <= lcnt_nxt;
         local_bus_clock_out_r <= local_bus_clock_out_nxt;
      end
   end

   assign awready = wst_r == hcg_pkg::HCG_W_IDLE && !aw_have_r;
   assign wready = wst_r == hcg_pkg::HCG_W_IDLE && !w_have_r;
   assign bvalid = wst_r == hcg_pkg::HCG_W_RESP;
   assign bresp = bresp_r;
   assign arready = rst_r == hcg_pkg::HCG_R_IDLE;
   assign rvalid = rst_r == hcg_pkg::HCG_R_DATA;
   assign rdata = rdata_r;
   assign rresp = rresp_r;
   assign sync_clock_out = sync_r;
   assign bus_clock_output_n = bclk_r;
   assign tree_phase = tree_r;
   assign memory_bus_clock_pair_p = mck_r;
   assign memory_bus_clock_pair_n = mck_n_r;
   assign local_sync_clock_out = local_bus_clock_out_r;
   assign local_bus_clock_out = {3{local_bus_clock_out_r}};
   assign csb_ratio = ratio_r;
   assign core_pll_setting = rcw_r[`HCG_RCW_CORE_HI:`HCG_RCW_CORE_LO];

   sequence s_wr_done;
      aw_have_r && w_have_r ##1 bvalid;
   endsequence

   AST_REF_SELECT: assert property (@(posedge aclk) disable iff (!aresetn)
      cfg_done_r && $stable(host_r) |-> ref_d_r == $past(host_r ? primary_input_clock : pci_clock_in))
      else $error("wrong reference clock selected");
   AST_HALF_ON_EDGE: assert property (@(posedge aclk) disable iff (!aresetn)
      cfg_done_r && host_r && $past(host_r) && $changed(half_r) |-> $rose(ref_d_r))
      else $error("halver moved without a rising reference");
   AST_SYNC_SOURCE: assert property (@(posedge aclk) disable iff (!aresetn)
      cfg_done_r && $past(cfg_done_r) |-> sync_r == $past(halve_r ? half_r : ref_d_r))
      else $error("sync out took the wrong source");
   AST_BUS_CLK_SEL: assert property (@(posedge aclk) disable iff (!aresetn)
      output_clock_control_reg_r[0] && $past(output_clock_control_reg_r[0]) |-> bclk_r[0] == $past(half_r))
      else $error("bus clock 0 not halved");
   AST_RATIO: assert property (@(posedge aclk) disable iff (!aresetn)
      cfg_done_r && $stable(rcw_r) ##1 $stable(rcw_r) |-> ratio_r == (halve_r ? 6'(system_pll_multiplier_mult << 1) : system_pll_multiplier_mult))
      else $error("system ratio wrong");
   AST_SYSTEM_PLL_MULTIPLIER_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
      system_pll_multiplier_code == `HCG_SYSTEM_PLL_MULTIPLIER_X16 |-> system_pll_multiplier_mult == `HCG_MULT_X16)
      else $error("code zero not sixteen");
   AST_MCK_TOGGLE: assert property (@(posedge aclk) disable iff (!aresetn)
      memory_bus_clock_pair_p |=> !memory_bus_clock_pair_p ##1 memory_bus_clock_pair_p)
      else $error("memory pair not at half rate");
   AST_LOCAL_BUS_CLOCK_OUT_DIV8: assert property (@(posedge aclk) disable iff (!aresetn)
      (local_bus_clock_control_r[1] && $rose(local_bus_clock_out_r)) ##1 local_bus_clock_control_r[1] [*3] |-> ($past(local_bus_clock_out_r, 2) && $past(local_bus_clock_out_r) && local_bus_clock_out_r) ##1 !local_bus_clock_out_r)
      else $error("local clock eighth divide wrong");
   AST_WRITE_ANSWER: assert property (@(posedge aclk) disable iff (!aresetn)
      (aw_addr_r == `HCG_OFF_SYSTEM_CLOCK_CONTROL_REG && w_strb_r == 4'hF) ##0 s_wr_done |-> system_clock_control_reg_r == $past(w_data_r))
      else $error("unit ratio register not written");
endmodule : hcg_clock_unit

//--- sim/hcg_clock_unit_tb.sv
/* bench for hcg_clock_unit: axi4-lite tasks, integer model, edge counters.
   assumes the bus slave answers each request after some wait, ended by the watchdog at worst. */
`timescale 1ns/100ps
module hcg_clock_unit_tb;
   logic aclk = 0, aresetn = 0; // clock, sync reset
   logic [7:0] awaddr = 0, araddr = 0; // bus addresses
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [31:0] wdata = 0, rcw_in = 0; // bus data, config word
   logic awready, wready, bvalid, arready, rvalid, sco, tph, mp, mn, lso;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic pin = 0, pci = 0, host = 1, hv = 0, hard = 0; // pins and straps
   logic [2:0] bco, lbo;
   logic [5:0] tick, ratio;
   logic [6:0] core;
   logic [7:0] cur, pv = 0; // watched clocks, last sample
   wire sync_in = sco;
   int mismatches = 0, num_checks = 0, cyc = 0, cnt[14];
   always #2 aclk = ~aclk;
   hcg_clock_unit u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .primary_input_clock(pin), .pci_clock_in(pci), .bus_sync_in(sync_in),
      .host_role_strap(host), .input_halve_strap(hv), .rcw_hard_sel(hard), .rcw_in(rcw_in),
      .sync_clock_out(sco), .bus_clock_output_n(bco), .tree_phase(tph),
      .memory_bus_clock_pair_p(mp), .memory_bus_clock_pair_n(mn), .local_sync_clock_out(lso),
      .local_bus_clock_out(lbo), .unit_clock_tick(tick), .csb_ratio(ratio), .core_pll_setting(core));
   // pin clocks: primary period 8, bus clock period 12 cycles
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc % 4 == 3) pin <= ~pin;
      if (cyc % 6 == 5) pci <= ~pci;
   end
   // count strobes and output toggles
   always @(posedge aclk) begin
      for (int i = 0; i < 6; i++) cnt[i] += int'(tick[i]);
      cur = {tph, lso, bco[2], mp, bco[1], bco[0], sco, lbo[0]};
      for (int i = 0; i < 8; i++) cnt[6+i] += int'(cur[i] != pv[i]);
      pv = cur;
   end
   task automatic give_verdict;
      if (mismatches == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   // counts may be one off from window phase
   task automatic near(input int g, input int e);
      num_checks++;
      if (g < e - 1 || g > e + 1) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : near
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ap, wp;
      ap = 1; wp = 1;
      @(posedge aclk);
      awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
      do begin
         @(posedge aclk);
         if (ap && awready) begin ap = 0; awvalid <= 0; end
         if (wp && wready) begin wp = 0; wvalid <= 0; end
      end while (!(bvalid && !ap && !wp));
      bready <= 0;
      chk(bresp, er);
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge aclk);
      araddr <= a; arvalid <= 1; rready <= 1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 0;
      end while (!rvalid);
      rready <= 0;
      chk(rdata, ed);
      chk(rresp, er);
   endtask : rdc
   // watchdog, far beyond the expected run
   initial begin
      repeat (20000) @(posedge aclk);
      mismatches++;
      give_verdict();
   end
   initial begin
      int s, o, l, m, rt;
      logic [31:0] w;
      void'($urandom(53));
      for (int r = 0; r < 4; r++) begin
         if (r == 0 || r == 3) begin
            s = 32'hFFC0_0001; o = 0; l = 0;
            if (r == 3) @(posedge aclk);
            aresetn <= 0; host <= (r == 0); hv <= (r == 0) & $urandom; hard <= $urandom;
            rcw_in <= $urandom;
            repeat (3) @(posedge aclk);
            aresetn <= 1;
            @(posedge aclk);
            w = hard ? 32'h0000_0040 : rcw_in;
            m = (w[7:4] < 2) ? 16 : w[7:4];
            rdc(8'h00, w, 2'h0);
            chk(core, w[14:8]);
            chk(ratio, 32'((1 + hv) * m));
            rdc(8'h08, 32'hFFC0_0001, 2'h0);
            rdc(8'h04, 0, 2'h0);
            rdc(8'h0C, 0, 2'h0);
            rdc(8'h10, {20'h0, w[7:4] == 1, host, w[0], w[1], 2'h0, 6'((1 + hv) * m)}, 2'h0);
            wr(8'h00, ~w, 2'h0);
            rdc(8'h00, w, 2'h0);
            wr(8'h20, $urandom, 2'h2);
            rdc(8'h20, 0, 2'h2);
         end else begin
            s = $urandom; o = $urandom % 8; l = $urandom % 4;
            for (int i = 2; i < 5; i++) if (s[31-2*i -: 2] == 2'h1) s[31-2*i -: 2] = 2'h2;
            wr(8'h08, s, 2'h0);
            wr(8'h04, o, 2'h0);
            wr(8'h0C, l, 2'h0);
            rdc(8'h08, s, 2'h0);
            rdc(8'h04, o, 2'h0);
            rdc(8'h0C, l, 2'h0);
         end
         repeat (8) @(posedge aclk);
         @(negedge aclk);
         foreach (cnt[i]) cnt[i] = 0;
         repeat (96) @(posedge aclk);
         #1;
         for (int i = 0; i < 5; i++) near(cnt[i], s[31-2*i -: 2] ? 96 / s[31-2*i -: 2] : 0);
         near(cnt[5], s[0] * 96);
         rt = host ? 24 : 16;
         near(cnt[7], (host && hv) ? rt / 2 : rt);
         near(cnt[8], (host && o[0]) ? rt / 2 : rt);
         near(cnt[9], (host && o[1]) ? rt / 2 : rt);
         near(cnt[10], 96);
         chk(mn ^ mp, 1);
         near(cnt[6], 96 >> ((l > 1) ? 2 : l));
         near(cnt[12], 96 >> ((l > 1) ? 2 : l));
         chk(lbo, {3{lso}});
         near(cnt[11], (host && o[2]) ? rt / 2 : rt);
         near(cnt[13], (host && hv) ? rt / 2 : rt);
      end
      give_verdict();
   end
endmodule : hcg_clock_unit_tb
